// ### common/ebc_defs.svh
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH

`define EBC_ADDR_W          8
`define EBC_CTRL_OFFSET     8'h00
`define EBC_SEQ_OFFSET      8'h04
`define EBC_REQ_HOLD_BIT    23
`define EBC_LOCK_HOLD_BIT   22
`define EBC_OWNER_BIT       21
`define EBC_WAIT_LSB        16
`define EBC_WAIT_MSB        20
`define EBC_LOWER_MSB       15
`define EBC_CTRL_RESET      24'h1fffff
`define EBC_WAIT_RESET      5'h1f
`define EBC_TRAIL1_LO_STD   5'h04
`define EBC_TRAIL1_LO_ALT   5'h03
`define EBC_TRAIL2_LO       5'h08
`define EBC_RESP_OKAY       2'h0
`define EBC_RESP_SLVERR     2'h2

`endif

// ### common/ebc_pkg.sv
package ebc_pkg;
    // access sequencer states, gray along idle-wait-trail-done
    typedef enum logic [1:0] {
        EBC_IDLE  = 2'h0,
        EBC_WAIT  = 2'h1,
        EBC_TRAIL = 2'h3,
        EBC_DONE  = 2'h2
    } ebc_seq_t;
endpackage

// ### common/ebc_timing_if.sv
`timescale 1ns/1ps
interface ebc_timing_if;
    logic       start;
    logic [4:0] wait_count;
    logic       alt_variant;
    logic       sample;
    logic       done;
    logic       busy;
    logic [1:0] trail;
    modport ctrl (output start, output wait_count, output alt_variant,
                  input sample, input done, input busy, input trail);
    modport seq  (input start, input wait_count, input alt_variant,
                  output sample, output done, output busy, output trail);
endinterface

// ### verilog/ebc_access_seq.sv
`timescale 1ns/1ps
`include "ebc_defs.svh"
module ebc_access_seq (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // timing handshake
    ebc_timing_if.seq tif
);
    typedef struct packed {
        ebc_pkg::ebc_seq_t state;
        logic [4:0]        cnt;
        logic [1:0]        trail;
        logic              sample;
        logic              done;
    } ebc_seq_state_t;

    ebc_seq_state_t r;
    ebc_seq_state_t next_r;
    logic [1:0]     trail_req;

    always_comb begin
        trail_req = 2'h0;
        if (tif.wait_count >= `EBC_TRAIL2_LO) begin
            trail_req = 2'h2; // RL9
        end else if (tif.wait_count >= (tif.alt_variant ?
                     `EBC_TRAIL1_LO_ALT : `EBC_TRAIL1_LO_STD)) begin
            trail_req = 2'h1; // RL8 RL11
        end
    end

    always_comb begin
        next_r = r;
        next_r.sample = 1'b0;
        next_r.done = 1'b0;
        case (r.state)
            ebc_pkg::EBC_IDLE: begin
                if (tif.start) begin
                    next_r.state = ebc_pkg::EBC_WAIT;
                    // zero treated as one wait state
                    next_r.cnt = (tif.wait_count == 5'h00) ? 5'h01
                                                           : tif.wait_count;
                    next_r.trail = trail_req;
                end
            end
            ebc_pkg::EBC_WAIT: begin
                if (r.cnt <= 5'h01) begin
                    // data sampled at end of wait states only
                    next_r.sample = 1'b1; // RL10
                    next_r.state = (r.trail != 2'h0) ? ebc_pkg::EBC_TRAIL
                                                     : ebc_pkg::EBC_DONE;
                end else begin
                    next_r.cnt = r.cnt - 5'h01; // RL5
                end
            end
            ebc_pkg::EBC_TRAIL: begin
                // trailing states only extend hold and release
                next_r.trail = r.trail - 2'h1; // RL10
                if (r.trail == 2'h1) begin
                    next_r.state = ebc_pkg::EBC_DONE;
                end
            end
            ebc_pkg::EBC_DONE: begin
                next_r.done = 1'b1;
                next_r.state = ebc_pkg::EBC_IDLE;
            end
            default: begin
                next_r.state = ebc_pkg::EBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '{state: ebc_pkg::EBC_IDLE, cnt: 5'h00, trail: 2'h0,
                   sample: 1'b0, done: 1'b0};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign tif.sample = r.sample;
    assign tif.done   = r.done;
    assign tif.busy   = (r.state != ebc_pkg::EBC_IDLE);
    assign tif.trail  = trail_req;
endmodule

// ### verilog/ebc_bus_control.sv
// Functional notes
// RL1: 24-bit control register, owner bit read-only
// RL2: request hold forces bus request always
// RL3: lock hold forces bus lock always
// RL4: owner status set while bus owned
// RL5: default-area wait count, reset thirty-one
// RL6: default area always uses SRAM timing
// RL7: software avoids writing zero wait count
// RL8: four to seven adds one trailing wait
// RL9: eight or more adds two trailing waits
// RL10: trailing waits never move data sample
// RL11: variant starts single trailing wait at three
// RL12: owner bit synchronous to arbitration grant
`timescale 1ns/1ps
`include "ebc_defs.svh"
module ebc_bus_control (
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // core access requests
    input  wire logic        ext_access_req,
    input  wire logic        ext_rmw_req,
    input  wire logic        area_match,
    input  wire logic        alt_variant,
    // external arbiter
    input  wire logic        bus_grant,
    output logic             bus_request_out,
    output logic             bus_lock_out,
    // default-area access timing
    output logic             access_busy,
    output logic             sram_select,
    output logic             data_sample,
    output logic             access_done,
    // lower wait fields for area logic
    output logic [15:0]      area_wait_fields
);
    typedef struct packed {
        logic [23:0] ctrl;
        logic        owner;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        pending;
        logic        rmw_pending;
        logic        req_out;
        logic        lock_out;
        logic        busy;
        logic        sram;
        logic        sample;
        logic        done;
        logic [1:0]  last_trail;
    } ebc_ctrl_state_t;

    ebc_ctrl_state_t r;
    ebc_ctrl_state_t next_r;
    ebc_timing_if    tif ();
    logic [23:0]     ctrl_view;
    logic [23:0]     wmask;
    logic            start_dflt;

    ebc_access_seq u_seq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .tif     (tif)
    );

    // read view splices live owner bit
    always_comb begin
        ctrl_view = r.ctrl;
        ctrl_view[`EBC_OWNER_BIT] = r.owner; // RL4
    end

    // byte lane mask from write strobes
    generate
        for (genvar i = 0; i < 3; i++) begin : g_lane
            assign wmask[i*8 +: 8] = {8{r.w_strb[i]}};
        end
    endgenerate

    // a new default-area access starts when owned and idle
    // the done cycle shows idle while pending is still set: no restart
    assign start_dflt = r.pending && !area_match && bus_grant && !tif.busy
                        && !tif.done;

    assign tif.start       = start_dflt;
    assign tif.wait_count  = r.ctrl[`EBC_WAIT_MSB:`EBC_WAIT_LSB]; // RL5
    assign tif.alt_variant = alt_variant; // RL11

    always_comb begin
        next_r = r;
        // owner status follows grant each cycle
        next_r.owner = bus_grant; // RL12 RL4

        // write channel: address and data in either order
        next_r.awready = 1'b0;
        next_r.wready  = 1'b0;
        if (s_axi_awvalid && !r.aw_got && !r.awready && !r.bvalid) begin
            next_r.awready = 1'b1;
        end
        if (r.awready && s_axi_awvalid) begin
            next_r.aw_got  = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_got && !r.wready && !r.bvalid) begin
            next_r.wready = 1'b1;
        end
        if (r.wready && s_axi_wvalid) begin
            next_r.w_got  = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = `EBC_RESP_OKAY;
            if (r.aw_addr[7:2] == `EBC_CTRL_OFFSET) begin
                // owner bit not writable
                next_r.ctrl = (r.ctrl & ~wmask) | (r.w_data[23:0] & wmask);
                next_r.ctrl[`EBC_OWNER_BIT] = 1'b0; // RL1
            end else if (r.aw_addr[7:2] != `EBC_SEQ_OFFSET >> 2) begin
                next_r.bresp = `EBC_RESP_SLVERR;
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // read channel
        next_r.arready = 1'b0;
        if (s_axi_arvalid && !r.arready && !r.rvalid) begin
            next_r.arready = 1'b1;
        end
        if (r.arready && s_axi_arvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = `EBC_RESP_OKAY;
            next_r.rdata  = 32'h0;
            if (s_axi_araddr[7:2] == `EBC_CTRL_OFFSET) begin
                next_r.rdata = {8'h00, ctrl_view}; // RL1
            end else if (s_axi_araddr[7:2] == `EBC_SEQ_OFFSET >> 2) begin
                next_r.rdata = {28'h0, r.last_trail, r.busy, r.pending};
            end else begin
                next_r.rresp = `EBC_RESP_SLVERR;
            end
        end
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end

        // pending access bookkeeping
        if (ext_access_req) begin
            next_r.pending = 1'b1;
        end
        if (ext_rmw_req) begin
            next_r.rmw_pending = 1'b1;
            next_r.pending = 1'b1;
        end
        if (r.pending && area_match && bus_grant) begin
            // configured areas are served by other logic
            next_r.pending = ext_access_req || ext_rmw_req;
            next_r.rmw_pending = ext_rmw_req;
        end
        if (start_dflt) begin
            next_r.last_trail = tif.trail;
        end
        if (tif.done) begin
            next_r.pending = ext_access_req || ext_rmw_req;
            next_r.rmw_pending = ext_rmw_req;
        end

        next_r.req_out = r.ctrl[`EBC_REQ_HOLD_BIT]
                         || ext_access_req || r.pending; // RL2
        next_r.lock_out = r.ctrl[`EBC_LOCK_HOLD_BIT]
                          || ext_rmw_req || r.rmw_pending; // RL3
        next_r.busy   = tif.busy || start_dflt;
        next_r.sram   = tif.busy || start_dflt; // RL6
        next_r.sample = tif.sample; // RL10
        next_r.done   = tif.done;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.ctrl <= `EBC_CTRL_RESET; // RL5
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign s_axi_awready    = r.awready;
    assign s_axi_wready     = r.wready;
    assign s_axi_bvalid     = r.bvalid;
    assign s_axi_bresp      = r.bresp;
    assign s_axi_arready    = r.arready;
    assign s_axi_rvalid     = r.rvalid;
    assign s_axi_rdata      = r.rdata;
    assign s_axi_rresp      = r.rresp;
    assign bus_request_out  = r.req_out;
    assign bus_lock_out     = r.lock_out;
    assign access_busy      = r.busy;
    assign sram_select      = r.sram;
    assign data_sample      = r.sample;
    assign access_done      = r.done;
    assign area_wait_fields = r.ctrl[`EBC_LOWER_MSB:0];
endmodule

// ### sim/ebc_bus_control_properties.sv
`timescale 1ns/1ps
module ebc_bus_control_properties (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    // core and arbiter side
    input wire logic        ext_access_req,
    input wire logic        ext_rmw_req,
    input wire logic        bus_request_out,
    input wire logic        bus_lock_out,
    // access timing
    input wire logic        access_busy,
    input wire logic        sram_select,
    input wire logic        data_sample,
    input wire logic        access_done,
    // register side
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [15:0] area_wait_fields
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    req_follows_a: assert property (
        ext_access_req && ce |=> bus_request_out)
        else $error("bus request missing after access request");
    lock_follows_a: assert property (
        ext_rmw_req && ce |=> bus_lock_out)
        else $error("bus lock missing after rmw request");
    sram_timing_a: assert property (
        access_busy |-> sram_select)
        else $error("default-area access without sram timing");
    sample_in_access_a: assert property (
        data_sample |-> access_busy)
        else $error("data sample outside an access");
    trail_bound_a: assert property (
        data_sample |-> ##[1:3] access_done)
        else $error("access end not within trailing bound");
    sample_pulse_a: assert property (
        data_sample |=> !data_sample)
        else $error("data sample longer than one cycle");
    reset_values_a: assert property (
        !$past(aresetn) |-> area_wait_fields == 16'hffff && !bus_request_out)
        else $error("wrong values after reset");
    read_clear_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not withdrawn");
endmodule

// ### sim/ebc_arbiter_model.sv
`timescale 1ns/1ps
module ebc_arbiter_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // arbitration
    input wire logic slow,
    input wire logic bus_request_out,
    output logic     bus_grant
);
    logic [2:0] wait_cnt;
    // grant after a delay, withdrawn as soon as request drops
    always_ff @(posedge aclk) begin
        if (!aresetn || !bus_request_out) begin
            bus_grant <= 1'b0;
            wait_cnt  <= 3'h0;
        end else if (!slow || wait_cnt == 3'h4) begin
            bus_grant <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule

// ### sim/ebc_bus_control_tb.sv
`timescale 1ns/1ps
`define EBC_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
    n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module ebc_bus_control_tb;
    logic        aclk, aresetn, ce, slow, bus_grant, area_match, alt_variant;
    logic        ext_access_req, ext_rmw_req, bus_request_out, bus_lock_out;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, access_busy, sram_select;
    logic        data_sample, access_done;
    logic [15:0] area_wait_fields;
    int          n_fail, total_checks;

    ebc_bus_control ebc_bus_control_i (.aclk, .aresetn, .ce, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ext_access_req, .ext_rmw_req, .area_match, .alt_variant, .bus_grant,
        .bus_request_out, .bus_lock_out, .access_busy, .sram_select,
        .data_sample, .access_done, .area_wait_fields);
    ebc_arbiter_model ebc_arbiter_model_i (.aclk, .aresetn, .slow,
        .bus_request_out, .bus_grant);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic conclude();
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok |= s_axi_awvalid && s_axi_awready;
            w_ok |= s_axi_wvalid && s_axi_wready;
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic t_regs();
        axr(8'h00);
        `EBC_CHK(rd[23:0], 24'h1fffff)
        `EBC_CHK(area_wait_fields, 16'hffff)
        axw(8'h00, 32'h0025a5a5);
        axr(8'h00);
        `EBC_CHK(rd[23:0], 24'h05a5a5)
        `EBC_CHK(area_wait_fields, 16'ha5a5)
        axw(8'h10, 32'h00000000);
        `EBC_CHK(rsp, 2'h2)
        axr(8'h10);
        `EBC_CHK({rsp, rd}, 34'h200000000)
    endtask

    task automatic t_hold();
        axw(8'h00, 32'h00dfffff);
        repeat (8) @(posedge aclk);
        `EBC_CHK({bus_request_out, bus_lock_out}, 2'h3)
        axr(8'h00);
        `EBC_CHK(rd[23:21], 3'h7)
        axw(8'h00, 32'h001fffff);
        repeat (8) @(posedge aclk);
        `EBC_CHK({bus_request_out, bus_lock_out}, 2'h0)
        axr(8'h00);
        `EBC_CHK(rd[23:21], 3'h0)
    endtask

    // one default-area access; cycles to sample and to end
    task automatic acc(input int n, input logic alt, output int ds, dd);
        axw(8'h00, {11'h000, n[4:0], 16'hffff});
        alt_variant <= alt;
        ext_access_req <= 1'b1;
        ext_rmw_req <= alt;
        dd = 0;
        @(posedge aclk);
        ext_access_req <= 1'b0;
        ext_rmw_req <= 1'b0;
        while (!access_done) begin
            @(posedge aclk);
            dd++;
            if (data_sample) begin
                ds = dd;
                `EBC_CHK({access_busy, sram_select}, 2'h3)
            end
        end
    endtask

    task automatic t_timing();
        int ns[8] = '{1, 3, 3, 4, 7, 8, 31, 2};
        logic [7:0] alts = 8'h04;
        int ds, dd, ds0, tr;
        for (int i = 0; i < 8; i++) begin
            slow <= (i == 7);
            acc(ns[i], alts[i], ds, dd);
            if (i == 0) ds0 = ds;
            tr = ns[i] >= 8 ? 2 : (ns[i] >= 4 || (alts[i] && ns[i] == 3));
            `EBC_CHK(ds - ds0, ns[i] - 1 + 4 * (i == 7))
            `EBC_CHK(dd - ds, tr + 1)
        end
    endtask

    // configured-area access: no default-area timing, request released
    task automatic t_area();
        int seen;
        seen = 0;
        area_match <= 1'b1;
        ext_access_req <= 1'b1;
        @(posedge aclk);
        ext_access_req <= 1'b0;
        repeat (12) begin
            @(posedge aclk);
            seen += access_busy;
        end
        `EBC_CHK(seen, 0)
        `EBC_CHK(bus_request_out, 1'b0)
        area_match <= 1'b0;
    endtask

    initial begin
        n_fail = 0;
        total_checks = 0;
        {aresetn, slow, area_match, alt_variant, ext_access_req} = 5'h00;
        {ext_rmw_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hf;
        ce = 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_hold();
        t_timing();
        t_area();
        conclude();
    end

    initial begin
        #200000;
        n_fail++;
        conclude();
    end
endmodule
bind ebc_bus_control ebc_bus_control_properties ebc_bus_control_properties_i (
    .aclk, .aresetn, .ce, .ext_access_req, .ext_rmw_req, .bus_request_out,
    .bus_lock_out, .access_busy, .sram_select, .data_sample, .access_done,
    .s_axi_rvalid, .s_axi_rready, .area_wait_fields);
